// ==== shared/esc_pkg.sv ====
// shared constants, types and helpers for the config-store controller
package esc_pkg;

  // ==========================================================
  // store geometry
  localparam int MEM_BYTES = 8192;               // 8 kB store
  localparam int PAGE_BYTES = 64;                // one programming page
  localparam int ADDR_W = 13;                    // byte address width
  localparam int PAGE_W = 6;                     // byte-in-page width
  localparam logic [12:0] PROD_RO_LAST = 13'h001f;   // page 0 bytes 0..31 read-only
  localparam logic [12:0] RESET_BASE = 13'h0040;     // register reset data
  localparam logic [12:0] KEY_BASE = 13'h1800;       // write-only key section
  localparam logic [12:0] KEY_LAST = 13'h1bff;
  localparam logic [12:0] RSP_TX_BASE = 13'h1c00;    // preset area, transmit part
  localparam logic [12:0] RSP_RX_BASE = 13'h1e00;    // preset area, receive part
  localparam logic [12:0] BOOT_FIRST = 13'h0020;     // first byte copied at startup
  localparam logic [8:0] BOOT_COUNT = 9'h0a0;        // config page half + reset area
  localparam logic [8:0] TX_PRESET_BYTES = 9'h010;   // 16 bytes per transmit preset
  localparam logic [8:0] RX_PRESET_BYTES = 9'h008;   // 8 bytes per receive preset
  localparam logic [8:0] LOAD_COUNT = 9'h018;        // 16 + 8
  localparam logic [8:0] PAGE_LAST = 9'h03f;

  // ==========================================================
  // configuration bytes in page 0
  localparam logic [12:0] CFG_I2C_ADDR = 13'h0020;
  localparam logic [12:0] CFG_IF = 13'h0021;
  localparam logic [12:0] CFG_SAM_ADDR = 13'h0022;
  localparam logic [12:0] CFG_DEF_RX = 13'h0023;
  localparam logic [12:0] CFG_DEF_TX = 13'h0024;
  localparam logic [12:0] CFG_TX_SEED_HI = 13'h0026;
  localparam logic [12:0] CFG_TX_SEED_LO = 13'h0027;
  localparam int IF_SPEED_BIT = 7;               // set: high speed plus
  localparam int IF_ADDR_SRC_BIT = 4;            // set: stored address byte
  localparam int IF_BSCAN_BIT = 3;               // set: boundary scan off
  localparam int IF_PIN_SEL_BIT = 2;             // 1xx: host chosen by pins
  localparam logic [4:0] PIN_ADDR_PREFIX = 5'h15;    // 10101xx

  // ==========================================================
  // register shadow layout (copy targets)
  localparam logic [6:0] SH_TX_DST = 7'h28;      // transmit preset lands here
  localparam logic [6:0] SH_RX_DST = 7'h38;      // receive preset lands here

  // ==========================================================
  // register port map
  localparam logic [7:0] REG_ADDR_LO = 8'h00;
  localparam logic [7:0] REG_ADDR_HI = 8'h01;
  localparam logic [7:0] REG_DATA = 8'h02;
  localparam logic [7:0] REG_CMD = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TX_SEL = 8'h05;
  localparam logic [7:0] REG_RX_SEL = 8'h06;
  localparam logic [7:0] REG_CRC_IN = 8'h07;
  localparam logic [7:0] REG_CRC_LO = 8'h08;
  localparam logic [7:0] REG_CRC_HI = 8'h09;
  localparam logic [7:0] REG_REVISION = 8'h7f;
  localparam int SHADOW_BIT = 7;                 // 80h..ffh read the shadow
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // commands written to REG_CMD
  typedef enum logic [7:0] {
    CMD_READ = 8'h01,
    CMD_PROG = 8'h02,
    CMD_LOAD = 8'h03,
    CMD_SEED = 8'h04
  } esc_cmd_t;

  // host interface codes
  typedef enum logic [2:0] {
    HOST_UART = 3'b000,
    HOST_I2C = 3'b001,
    HOST_SPI = 3'b010,
    HOST_I2C_LS = 3'b011
  } esc_host_t;

  // controller states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10,
    ST_LOAD = 2'b11
  } esc_state_t;

  // decoded configuration handed to the interface logic
  typedef struct packed {
    logic [6:0] i2c_addr;       // host-side slave address
    logic speed_plus;           // i2c_speed_variant_sel
    logic bscan_en;             // boundary scan port on
    logic host_from_pins;       // host choice deferred to pins
    logic [2:0] host_sel;       // host interface code
    logic [6:0] sam_addr;       // secure_key_module bus address
  } esc_cfg_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } esc_bus_t;

  // one byte step of the transmit checksum
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // bytes that a program operation may change
  function automatic logic wr_ok(input logic [12:0] a);
    return (a > PROD_RO_LAST) && (a < RSP_TX_BASE);
  endfunction

  // bytes that never read back
  function automatic logic key_sec(input logic [12:0] a);
    return (a >= KEY_BASE) && (a <= KEY_LAST);
  endfunction

endpackage

// ==== hw/esc_nv_array.sv ====
// byte-wide store array with one synchronous read and one write port
module esc_nv_array #(
  parameter int DEPTH = 8192,
  parameter int AW = 13
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  // ==========================================================
  // elaboration check
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("depth must equal two to the address width");
  end

  // ==========================================================
  // storage
  logic [7:0] mem [DEPTH];  // contents survive reset, as a store should

  // read first, read gives the old byte on a collision
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ==== hw/esc_nv_ctrl.sv ====
// configuration store controller: startup copy, page program, preset load
// Contract
// - 8 kB store, 64-byte pages, contiguous addresses
// - program at most one page per operation
// - five sections with their access rights
// - page 0: bytes 0-31 read-only, 32-63 writable
// - revision hardwired at register 7Fh
// - slave address from straps or stored byte
// - interface bit 7 selects speed variant
// - interface bit 3 disables boundary scan
// - interface bits 2:0 select host interface
// - secure module address always from store
// - presets: 16 transmit, 8 receive bytes
// - transmit checksum seeded from stored seed
// - startup copies reset area into registers
// - load command copies preset into registers
//
// The strobed register port was decided locally.
module esc_nv_ctrl #(
  parameter logic [7:0] REVISION = 8'h5a  // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic addr_strap_pin_a,
  input wire logic addr_strap_pin_b,
  output esc_pkg::esc_cfg_t cfg,
  output logic busy
);

  // ==========================================================
  // state
  typedef struct packed {
    esc_pkg::esc_state_t fsm;
    logic [12:0] addr;         // software byte address
    logic [7:0] data;          // last byte read
    logic [7:0] rdata;         // read answer, one cycle
    logic [8:0] cnt;           // step counter of copies
    logic [63:0] mask;         // page buffer bytes loaded
    logic pend;                // a store read returns now
    logic [12:0] pend_src;
    logic [6:0] pend_dst;
    logic pend_sh;             // returning byte goes to shadow
    logic pend_dat;            // returning byte goes to data
    logic err;                 // sticky refused-byte flag
    logic [7:0] i2c_byte;
    logic [7:0] if_byte;
    logic [7:0] sam_byte;
    logic [15:0] seed;
    logic [15:0] crc;
    logic [4:0] tx_sel;        // transmit preset index
    logic [5:0] rx_sel;        // receive preset index
    logic [1:0] strap_s1;      // first sync stage
    logic [1:0] strap_s2;      // second sync stage
    esc_pkg::esc_cfg_t cfg;
    logic busy;
  } esc_st_t;

  esc_st_t st_q;
  esc_st_t st_d;

  logic [7:0] page_buf [esc_pkg::PAGE_BYTES];  // bytes waiting for program
  logic [7:0] shadow [128];                    // behaviour registers
  logic mem_we;
  logic [12:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [12:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [12:0] src;
  logic [6:0] dst;
  logic err_set;
  logic idle_wr;

  // ==========================================================
  // store array
  esc_nv_array #(
    .DEPTH(esc_pkg::MEM_BYTES),
    .AW(esc_pkg::ADDR_W)
  ) u_array (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // software fills the page buffer one byte at a time
  always_ff @(posedge clk) begin
    if (idle_wr && reg_addr == esc_pkg::REG_DATA) begin
      page_buf[st_q.addr[5:0]] <= reg_wdata;
    end
    if (st_q.pend && st_q.pend_sh) begin
      shadow[st_q.pend_dst] <= mem_rdata;
    end
  end

  // preset addresses: transmit part then receive part
  always_comb begin
    if (st_q.cnt < esc_pkg::TX_PRESET_BYTES) begin
      src = esc_pkg::RSP_TX_BASE + {4'h0, st_q.tx_sel, 4'h0} + {4'h0, st_q.cnt};
      dst = esc_pkg::SH_TX_DST + st_q.cnt[6:0];
    end else begin
      src = esc_pkg::RSP_RX_BASE + {4'h0, st_q.rx_sel, 3'h0}
          + {4'h0, st_q.cnt - esc_pkg::TX_PRESET_BYTES};
      dst = esc_pkg::SH_RX_DST + 7'(st_q.cnt - esc_pkg::TX_PRESET_BYTES);
    end
  end

  assign idle_wr = reg_wr && st_q.fsm == esc_pkg::ST_IDLE;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    st_d.pend = 1'b0;
    st_d.pend_dat = 1'b0;
    st_d.pend_sh = 1'b0;
    err_set = 1'b0;
    mem_we = 1'b0;
    mem_waddr = {st_q.addr[12:6], st_q.cnt[5:0]};
    mem_wdata = page_buf[st_q.cnt[5:0]];
    mem_raddr = st_q.addr;
    st_d.strap_s1 = {addr_strap_pin_b, addr_strap_pin_a};
    st_d.strap_s2 = st_q.strap_s1;
    // a byte read last cycle comes back now
    if (st_q.pend) begin
      if (st_q.pend_dat) begin
        st_d.data = esc_pkg::key_sec(st_q.pend_src) ? 8'h00 : mem_rdata;
      end else begin
        unique case (st_q.pend_src)
          esc_pkg::CFG_I2C_ADDR: st_d.i2c_byte = mem_rdata;
          esc_pkg::CFG_IF: st_d.if_byte = mem_rdata;
          esc_pkg::CFG_SAM_ADDR: st_d.sam_byte = mem_rdata;
          esc_pkg::CFG_DEF_RX: st_d.rx_sel = mem_rdata[5:0];
          esc_pkg::CFG_DEF_TX: st_d.tx_sel = mem_rdata[4:0];
          esc_pkg::CFG_TX_SEED_HI: st_d.seed[15:8] = mem_rdata;
          esc_pkg::CFG_TX_SEED_LO: st_d.seed[7:0] = mem_rdata;
          default: st_d.seed = st_d.seed;
        endcase
      end
    end
    unique case (st_q.fsm)
      // startup copy of config bytes and reset area
      esc_pkg::ST_BOOT: begin
        mem_raddr = esc_pkg::BOOT_FIRST + {4'h0, st_q.cnt};
        st_d.pend = 1'b1;
        st_d.pend_src = mem_raddr;
        st_d.pend_sh = mem_raddr >= esc_pkg::RESET_BASE;
        st_d.pend_dst = 7'(mem_raddr - esc_pkg::RESET_BASE);
        st_d.cnt = st_q.cnt + 9'h001;
        if (st_q.cnt == esc_pkg::BOOT_COUNT - 9'h001) begin
          st_d.fsm = esc_pkg::ST_IDLE;
          st_d.cnt = 9'h000;
        end
      end
      // wait for commands
      esc_pkg::ST_IDLE: begin
        if (reg_wr) begin
          unique case (reg_addr)
            esc_pkg::REG_ADDR_LO: st_d.addr[7:0] = reg_wdata;
            esc_pkg::REG_ADDR_HI: st_d.addr[12:8] = reg_wdata[4:0];
            esc_pkg::REG_DATA: begin
              st_d.mask[st_q.addr[5:0]] = 1'b1;
              st_d.addr[5:0] = st_q.addr[5:0] + 6'h01;
            end
            esc_pkg::REG_TX_SEL: st_d.tx_sel = reg_wdata[4:0];
            esc_pkg::REG_RX_SEL: st_d.rx_sel = reg_wdata[5:0];
            esc_pkg::REG_CMD: begin
              unique case (reg_wdata)
                esc_pkg::CMD_READ: begin
                  st_d.pend = 1'b1;
                  st_d.pend_dat = 1'b1;
                  st_d.pend_src = st_q.addr;
                  st_d.addr = st_q.addr + 13'h0001;
                end
                esc_pkg::CMD_PROG: st_d.fsm = esc_pkg::ST_PROG;
                esc_pkg::CMD_LOAD: st_d.fsm = esc_pkg::ST_LOAD;
                default: st_d.fsm = esc_pkg::ST_IDLE;
              endcase
            end
            default: st_d.fsm = esc_pkg::ST_IDLE;
          endcase
        end
      end
      // one page, one byte per cycle
      esc_pkg::ST_PROG: begin
        if (st_q.mask[st_q.cnt[5:0]]) begin
          mem_we = esc_pkg::wr_ok(mem_waddr);
          err_set = !mem_we;
        end
        if (mem_we && mem_waddr == esc_pkg::CFG_I2C_ADDR) st_d.i2c_byte = mem_wdata;
        if (mem_we && mem_waddr == esc_pkg::CFG_IF) st_d.if_byte = mem_wdata;
        if (mem_we && mem_waddr == esc_pkg::CFG_SAM_ADDR) st_d.sam_byte = mem_wdata;
        st_d.cnt = st_q.cnt + 9'h001;
        if (st_q.cnt == esc_pkg::PAGE_LAST) begin
          st_d.fsm = esc_pkg::ST_IDLE;
          st_d.cnt = 9'h000;
          st_d.mask = '0;
        end
      end
      // preset copy from the read-only area
      esc_pkg::ST_LOAD: begin
        mem_raddr = src;
        st_d.pend = 1'b1;
        st_d.pend_sh = 1'b1;
        st_d.pend_src = src;
        st_d.pend_dst = dst;
        st_d.cnt = st_q.cnt + 9'h001;
        if (st_q.cnt == esc_pkg::LOAD_COUNT - 9'h001) begin
          st_d.fsm = esc_pkg::ST_IDLE;
          st_d.cnt = 9'h000;
        end
      end
    endcase
    // checksum works in any state; seed reload is a command
    if (reg_wr && reg_addr == esc_pkg::REG_CRC_IN) begin
      st_d.crc = esc_pkg::crc_step(st_q.crc, reg_wdata);
    end
    if (idle_wr && reg_addr == esc_pkg::REG_CMD && reg_wdata == esc_pkg::CMD_SEED) begin
      st_d.crc = st_q.seed;
    end
    // refused bytes flag: a new set beats a clear
    st_d.err = err_set || (st_q.err && !(reg_wr && reg_addr == esc_pkg::REG_STATUS
               && reg_wdata[esc_pkg::ST_ERR_BIT]));
    // register reads answer one cycle later
    if (reg_rd) begin
      if (reg_addr[esc_pkg::SHADOW_BIT]) begin
        st_d.rdata = shadow[reg_addr[6:0]];
      end else begin
        unique case (reg_addr)
          esc_pkg::REG_ADDR_LO: st_d.rdata = st_q.addr[7:0];
          esc_pkg::REG_ADDR_HI: st_d.rdata = {3'h0, st_q.addr[12:8]};
          esc_pkg::REG_DATA: st_d.rdata = st_q.data;
          esc_pkg::REG_STATUS: st_d.rdata = {6'h00, st_q.err, st_q.busy};
          esc_pkg::REG_TX_SEL: st_d.rdata = {3'h0, st_q.tx_sel};
          esc_pkg::REG_RX_SEL: st_d.rdata = {2'h0, st_q.rx_sel};
          esc_pkg::REG_CRC_LO: st_d.rdata = st_q.crc[7:0];
          esc_pkg::REG_CRC_HI: st_d.rdata = st_q.crc[15:8];
          esc_pkg::REG_REVISION: st_d.rdata = REVISION;
          default: st_d.rdata = 8'h00;
        endcase
      end
    end
    // decoded configuration, one cycle behind its bytes
    st_d.cfg.i2c_addr = st_q.if_byte[esc_pkg::IF_ADDR_SRC_BIT] ? st_q.i2c_byte[6:0]
                      : {esc_pkg::PIN_ADDR_PREFIX, st_q.strap_s2};
    st_d.cfg.speed_plus = st_q.if_byte[esc_pkg::IF_SPEED_BIT];
    st_d.cfg.bscan_en = !st_q.if_byte[esc_pkg::IF_BSCAN_BIT];
    st_d.cfg.host_from_pins = st_q.if_byte[esc_pkg::IF_PIN_SEL_BIT];
    st_d.cfg.host_sel = st_q.if_byte[2:0];
    st_d.cfg.sam_addr = st_q.sam_byte[6:0];
    st_d.busy = st_d.fsm != esc_pkg::ST_IDLE || st_d.pend;
  end

  // ==========================================================
  // state register; reset values are the documented defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.fsm <= esc_pkg::ST_BOOT;
      st_q.if_byte <= 8'h80;  // high speed plus, pins, scan on
      // decoded outputs agree with the default interface byte from the start
      st_q.cfg.i2c_addr <= {esc_pkg::PIN_ADDR_PREFIX, 2'b00};
      st_q.cfg.speed_plus <= 1'b1;
      st_q.cfg.bscan_en <= 1'b1;
      st_q.busy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign cfg = st_q.cfg;
  assign busy = st_q.busy;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence load_begin_s;
    reg_wr && reg_addr == esc_pkg::REG_CMD && reg_wdata == esc_pkg::CMD_LOAD
      && st_q.fsm == esc_pkg::ST_IDLE;
  endsequence
  sequence load_end_s;
    st_q.fsm == esc_pkg::ST_LOAD ##23 st_q.fsm == esc_pkg::ST_LOAD
      ##1 st_q.fsm == esc_pkg::ST_IDLE;
  endsequence

  revision_read_a: assert property (reg_rd && reg_addr == esc_pkg::REG_REVISION
    |=> reg_rdata == REVISION) else $error("revision read wrong");
  pin_address_a: assert property (!st_q.if_byte[esc_pkg::IF_ADDR_SRC_BIT]
    |=> cfg.i2c_addr == {esc_pkg::PIN_ADDR_PREFIX, $past(st_q.strap_s2)})
    else $error("pin address not used");
  speed_variant_a: assert property (##1 cfg.speed_plus == $past(st_q.if_byte[7]))
    else $error("speed variant mismatch");
  scan_enable_a: assert property (st_q.if_byte[3] |=> !cfg.bscan_en)
    else $error("boundary scan not disabled");
  host_select_a: assert property (##1 cfg.host_sel == $past(st_q.if_byte[2:0])
    && cfg.host_from_pins == $past(st_q.if_byte[2])) else $error("host select wrong");
  sam_address_a: assert property (##1 cfg.sam_addr == $past(st_q.sam_byte[6:0]))
    else $error("secure module address wrong");
  ro_write_a: assert property (mem_we |-> mem_waddr > esc_pkg::PROD_RO_LAST
    && mem_waddr < esc_pkg::RSP_TX_BASE) else $error("read-only byte written");
  key_read_a: assert property (st_q.pend && st_q.pend_dat
    && esc_pkg::key_sec(st_q.pend_src) |=> st_q.data == 8'h00) else $error("key leaked");
  page_wrap_a: assert property (idle_wr && reg_addr == esc_pkg::REG_DATA
    |=> st_q.addr[12:6] == $past(st_q.addr[12:6])) else $error("page crossed");
  boot_copy_a: assert property ($fell(rst) |-> ##[159:161]
    st_q.fsm == esc_pkg::ST_IDLE) else $error("startup copy length wrong");
  preset_load_a: assert property (load_begin_s |=> load_end_s)
    else $error("preset copy length wrong");
  crc_step_a: assert property (reg_wr && reg_addr == esc_pkg::REG_CRC_IN
    |=> st_q.crc == esc_pkg::crc_step($past(st_q.crc), $past(reg_wdata)))
    else $error("checksum step wrong");

endmodule

// ==== sim/esc_host_model.sv ====
// host controller model that drives the register port of the store controller
module esc_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic busy,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // bus master state
  int n_wait_fail;  // idle waits that ran out
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_wait_fail = 0;
  end
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // bounded wait, a hang is counted rather than waited out
  task automatic wait_idle();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 2000; i++) begin
      #1;
      if (busy === 1'b0) return;
      @(posedge clk);
    end
    n_wait_fail++;
  endtask
  // store pointer is split over two registers
  task automatic set_addr(input logic [12:0] a);
    wr(esc_pkg::REG_ADDR_LO, a[7:0]);
    wr(esc_pkg::REG_ADDR_HI, {3'h0, a[12:8]});
  endtask
  // callers hand at most one page of bytes per operation
  task automatic prog(input logic [12:0] a, input logic [7:0] q[$]);
    set_addr(a);
    foreach (q[i]) wr(esc_pkg::REG_DATA, q[i]);
    wr(esc_pkg::REG_CMD, esc_pkg::CMD_PROG);
    wait_idle();
  endtask
  // single byte fetch from the store
  task automatic rd_store(input logic [12:0] a, output logic [7:0] d);
    set_addr(a);
    wr(esc_pkg::REG_CMD, esc_pkg::CMD_READ);
    wait_idle();
    rd(esc_pkg::REG_DATA, d);
  endtask
  // identity looks at the middle code byte only, never at maker data
  task automatic product_code(output logic [7:0] d);
    rd_store(13'h0001, d);
  endtask
endmodule

// ==== sim/test_esc_nv_ctrl.sv ====
// self-checking bench for the configuration store controller
module test_esc_nv_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals and reference store
  logic clk, rst, pa, pb, reg_wr, reg_rd, busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  esc_pkg::esc_cfg_t cfg;
  int n_mismatch, cmp_count;
  logic [7:0] m [int];  // bytes the bench knows were programmed
  esc_nv_ctrl i_esc_nv_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr_strap_pin_a(pa), .addr_strap_pin_b(pb), .cfg(cfg), .busy(busy));
  esc_host_model i_esc_host_model (.clk(clk), .reg_rdata(reg_rdata), .busy(busy),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    n_mismatch += i_esc_host_model.n_wait_fail;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // reset for 3 cycles, then let boot copy and strap sync settle
  task automatic reboot();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    i_esc_host_model.wait_idle();
    repeat (3) @(posedge clk);
  endtask
  // reference program: page wrap, protected bytes left alone
  task automatic mprog(input logic [12:0] a, input logic [7:0] q[$]);
    logic [12:0] b;
    foreach (q[i]) begin
      b = {a[12:6], a[5:0] + 6'(i)};
      if (b > 13'h001f && b < 13'h1c00) m[b] = q[i];
    end
    i_esc_host_model.prog(a, q);
  endtask
  // key bytes never read back, everything else from the reference
  task automatic cmp_store(input logic [12:0] a);
    logic [7:0] d;
    i_esc_host_model.rd_store(a, d);
    chk("store byte", d, (a >= 13'h1800 && a < 13'h1c00) ? 8'h00 : m[a]);
  endtask
  // error flag must read as given, then is cleared by writing one
  task automatic chk_err(input logic v);
    logic [7:0] d;
    i_esc_host_model.rd(esc_pkg::REG_STATUS, d);
    chk("status err", d[1], v);
    i_esc_host_model.wr(esc_pkg::REG_STATUS, 8'h02);
  endtask
  // msb-first checksum step, polynomial 1021
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int j = 0; j < 8; j++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    return c;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d, h, ifb, p0;
    logic [7:0] q[$];
    logic [15:0] crc;
    esc_pkg::esc_cfg_t e;
    rst = 1'b1;
    pa = 1'b0;
    pb = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(32'h9f6a));
    reboot();
    i_esc_host_model.rd(esc_pkg::REG_REVISION, d);
    chk("revision", d, 8'h5a);
    i_esc_host_model.rd(8'h0a, d);
    chk("unmapped", d, 8'h00);
    // production byte keeps its content
    i_esc_host_model.product_code(p0);
    q = '{8'($urandom)};
    i_esc_host_model.prog(13'h0001, q);
    i_esc_host_model.product_code(d);
    chk("product byte", d, p0);
    chk_err(1'b1);
    chk_err(1'b0);
    mprog(13'h1c05, q);
    chk_err(1'b1);
    // key byte is written but reads as zero
    mprog(13'h1805, q);
    cmp_store(13'h1805);
    // full page starting mid-page wraps inside it
    q = {};
    repeat (64) q.push_back(8'($urandom));
    mprog(13'h0130, q);
    cmp_store(13'h012f);
    cmp_store(13'h0130);
    repeat (6) cmp_store(13'h0100 + 13'($urandom_range(63)));
    q = {};
    repeat (64) q.push_back(8'($urandom));
    mprog(13'h0040, q);
    // every host code, both address sources
    for (int k = 0; k < 6; k++) begin
      ifb = 8'($urandom);
      ifb[2:0] = (k < 4) ? 3'(k) : 3'(4 + $urandom_range(3));
      ifb[4] = k[0];
      q = {};
      repeat (8) q.push_back(8'($urandom));
      q[1] = ifb;
      q[3] = 8'($urandom_range(63));
      q[4] = 8'($urandom_range(31));
      mprog(13'h0020, q);
      @(posedge clk);
      pa <= 1'($urandom);
      pb <= 1'($urandom);
      reboot();
      e.i2c_addr = ifb[4] ? q[0][6:0] : {5'h15, pb, pa};
      e.speed_plus = ifb[7];
      e.bscan_en = ~ifb[3];
      e.host_from_pins = ifb[2];
      e.sam_addr = q[2][6:0];
      chk("cfg", {cfg.i2c_addr, cfg.speed_plus, cfg.bscan_en, cfg.host_from_pins,
        cfg.sam_addr}, {e.i2c_addr, e.speed_plus, e.bscan_en, e.host_from_pins,
        e.sam_addr});
      if (!ifb[2]) chk("host sel", cfg.host_sel, ifb[2:0]);
    end
    // shadow copies of the reset area, incl. preset target edges
    i_esc_host_model.rd(8'h85, d);
    chk("shadow 05", d, m[13'h0045]);
    i_esc_host_model.rd(8'ha8, d);
    chk("shadow 28", d, m[13'h0068]);
    i_esc_host_model.rd(8'hbf, d);
    chk("shadow 3f", d, m[13'h007f]);
    i_esc_host_model.rd(esc_pkg::REG_RX_SEL, d);
    chk("default rx", d, q[3]);
    // checksum reseeded from the stored seed
    i_esc_host_model.wr(esc_pkg::REG_CMD, esc_pkg::CMD_SEED);
    i_esc_host_model.wait_idle();
    crc = {q[6], q[7]};
    repeat (4) begin
      d = 8'($urandom);
      i_esc_host_model.wr(esc_pkg::REG_CRC_IN, d);
      crc = crc_ref(crc, d);
    end
    i_esc_host_model.rd(esc_pkg::REG_CRC_LO, d);
    i_esc_host_model.rd(esc_pkg::REG_CRC_HI, h);
    chk("crc", {h, d}, crc);
    // preset load overwrites only the two target windows
    i_esc_host_model.wr(esc_pkg::REG_TX_SEL, 8'h1f);
    i_esc_host_model.wr(esc_pkg::REG_RX_SEL, 8'h3f);
    i_esc_host_model.wr(esc_pkg::REG_CMD, esc_pkg::CMD_LOAD);
    i_esc_host_model.wait_idle();
    i_esc_host_model.rd(8'h85, d);
    chk("load keeps", d, m[13'h0045]);
    i_esc_host_model.rd(8'ha8, d);
    chk("load tx", d !== m[13'h0068], 1'b1);
    i_esc_host_model.rd(8'hbf, d);
    chk("load rx", d !== m[13'h007f], 1'b1);
    wrap_up();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
